// file: hdl/cdp_pkg.sv
// Shared constants for the configuration data port.
// Assumes a 125 MHz system clock and a separate serial link clock.
package cdp_pkg;
   localparam int BYTE_W = 8;
   localparam int ADDR_BASE_W = 18;
   localparam int ADDR_EXT_W = 4;
   localparam int ADDR_W = ADDR_BASE_W + ADDR_EXT_W;
   localparam int FIFO_DEPTH = 2;
   localparam logic [2:0] MODE_MSER = 3'h0;
   localparam logic [2:0] MODE_SSER = 3'h7;
   localparam logic [2:0] MODE_MPUP = 3'h4;
   localparam logic [2:0] MODE_MPDN = 3'h6;
   localparam logic [2:0] MODE_SPER = 3'h3;
   localparam logic [2:0] MODE_APER = 3'h5;
   localparam logic [ADDR_W-1:0] ADDR_UP_START = 22'h000000;
   localparam logic [ADDR_W-1:0] ADDR_DN_BASE = 22'h03ffff;
   localparam logic [ADDR_W-1:0] ADDR_DN_EXT = 22'h3fffff;
   localparam logic [6:0] RD_FILL = 7'h7f;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam int CLK_PERIOD_NS = 8;
   localparam int CLK_FREQ_KHZ = 125000;
   localparam int CFG_CLOCK_FREQ_KHZ = 1000;
   localparam int CFG_CLOCK_HALF_CYC = CLK_FREQ_KHZ / (2 * CFG_CLOCK_FREQ_KHZ);
   localparam int ADDR_SETTLE_NS = 100;
   localparam int ADDR_SETTLE_CYC = (ADDR_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef enum logic [0:0] {FS_IDLE, FS_WAIT} cdp_fetch_e;

   function automatic logic cdp_is_mpar(input logic [2:0] m);
      return (m == MODE_MPUP) || (m == MODE_MPDN);
   endfunction : cdp_is_mpar

   function automatic logic cdp_is_periph(input logic [2:0] m);
      return (m == MODE_APER) || (m == MODE_SPER);
   endfunction : cdp_is_periph
endpackage : cdp_pkg

// file: hdl/cdp_config_data_port.sv
// Configuration data port: host strobes, PROM fetch, serial pass-through.
// Assumes pins are asynchronous to clk_i; serial data is synchronous to cfg_clk_i.
`timescale 1ns/1ps

// Operation
// - The port counts as selected only while the low-active select is low and the high-active select is high.
// - In peripheral modes a low write strobe while selected stores the data pins as one byte in the buffer.
// - In peripheral modes a low read strobe while selected drives ready on the top data pin and ones on the other seven.
// - Write and read strobes should not overlap, and if they do the write is done and the read ignored.
// - In express mode the high-active select acts as the serial enable of the chain.
// - Master parallel mode drives an 18-bit address to the configuration PROM.
// - With the extended address space enabled, four more upper address bits are driven.
// - Master parallel and peripheral modes take data as whole bytes from the eight data pins.
// - Serial modes sample the serial input on each rising edge of the link clock.
// - In parallel modes the serial input pin is bit zero of the data byte.
// - Outside express mode the serial output repeats each bit on a falling edge 1.5 periods after sampling.
// - In express mode the serial output carries the enable for the next device in the chain.
// - After configuration all port pins are released for user logic.
// - Asynchronous peripheral mode emits a burst of generated clocks to serialise each byte.
module cdp_config_data_port #(
   parameter int FIFO_DEPTH = cdp_pkg::FIFO_DEPTH,
   parameter int CFG_CLOCK_HALF = cdp_pkg::CFG_CLOCK_HALF_CYC,
   parameter int SETTLE_CYC = cdp_pkg::ADDR_SETTLE_CYC
) (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic cfg_clk_i,
   input wire logic chip_select_low_active_n_i,
   input wire logic chip_select_high_active_i,
   input wire logic write_strobe_n_i,
   input wire logic read_strobe_n_i,
   input wire logic [2:0] mode_select_pins_i,
   input wire logic express_mode_i,
   input wire logic addr_ext_en_i,
   input wire logic cfg_done_i,
   input wire logic cfg_loaded_i,
   input wire logic [cdp_pkg::BYTE_W-1:0] cfg_byte_pins_i,
   output logic [cdp_pkg::BYTE_W-1:0] cfg_byte_pins_o,
   output logic cfg_byte_pins_oe_o,
   output logic [cdp_pkg::ADDR_BASE_W-1:0] prom_addr_base_o,
   output logic [cdp_pkg::ADDR_EXT_W-1:0] prom_addr_ext_o,
   output logic prom_addr_oe_o,
   output logic prom_addr_ext_oe_o,
   output logic cfg_clock_o,
   output logic cfg_clock_oe_o,
   output logic ser_out_o,
   output logic ser_out_oe_o,
   output logic cfg_bit_o,
   output logic cfg_bit_valid_o,
   input wire logic cfg_bit_ready_i
);
   import cdp_pkg::*;

   localparam int PW = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
   localparam int CW = $clog2(FIFO_DEPTH + 1);
   localparam int DW = $clog2(CFG_CLOCK_HALF + 1);
   localparam int SW = $clog2(SETTLE_CYC + 1);
   localparam int SYNC_W = 17;
   localparam logic [PW-1:0] PTR_LAST = PW'(FIFO_DEPTH - 1);
   localparam logic [CW-1:0] CNT_FULL = CW'(FIFO_DEPTH);
   localparam logic [DW-1:0] DIV_LAST = DW'(CFG_CLOCK_HALF - 1);
   localparam logic [SW-1:0] SETTLE_LAST = SW'(SETTLE_CYC - 1);

   // Pin synchronisers, system domain
   logic [SYNC_W-1:0] pin_s1_q;
   logic [SYNC_W-1:0] pin_s2_q;
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         pin_s1_q <= '0;
         pin_s2_q <= '0;
      end else begin
         pin_s1_q <= {chip_select_low_active_n_i, chip_select_high_active_i, write_strobe_n_i,
                      read_strobe_n_i, mode_select_pins_i, addr_ext_en_i, cfg_done_i, cfg_byte_pins_i};
         pin_s2_q <= pin_s1_q;
      end
   end

   logic cs_n_s, cs_s, ws_n_s, rs_n_s, ext_s, done_s;
   logic [2:0] mode_s;
   logic [BYTE_W-1:0] byte_s;
   assign {cs_n_s, cs_s, ws_n_s, rs_n_s, mode_s, ext_s, done_s, byte_s} = pin_s2_q;

   logic sel, wr_lvl, rd_lvl, periph, mpar;
   assign sel = !cs_n_s && cs_s;
   assign wr_lvl = sel && !ws_n_s;
   assign rd_lvl = sel && !rs_n_s && ws_n_s;
   assign periph = cdp_is_periph(mode_s);
   assign mpar = cdp_is_mpar(mode_s);

   // Two-entry byte buffer
   logic [BYTE_W-1:0] fifo_mem_q [FIFO_DEPTH];
   logic [PW-1:0] wr_ptr_q, rd_ptr_q;
   logic [CW-1:0] cnt_q;
   logic fifo_full, fifo_empty, push, push_ok, pop;
   logic host_push, fetch_push, ser_push;
   logic [BYTE_W-1:0] push_data;
   logic [BYTE_W-1:0] ser_word_q;
   assign fifo_full = (cnt_q == CNT_FULL);
   assign fifo_empty = (cnt_q == '0);
   assign push = host_push || fetch_push || ser_push;
   assign push_ok = push && !fifo_full;
   // Serial word is held stable across the toggle crossing
   assign push_data = ser_push ? ser_word_q : byte_s;

   always_ff @(posedge clk_i) begin
      if (push_ok) begin
         fifo_mem_q[wr_ptr_q] <= push_data;
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push_ok) begin
            wr_ptr_q <= (wr_ptr_q == PTR_LAST) ? '0 : wr_ptr_q + 1'b1;
         end
         if (pop) begin
            rd_ptr_q <= (rd_ptr_q == PTR_LAST) ? '0 : rd_ptr_q + 1'b1;
         end
         if (push_ok && !pop) begin
            cnt_q <= cnt_q + 1'b1;
         end else if (pop && !push_ok) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end

   // Host write capture, one byte per strobe
   logic wr_lvl_q;
   assign host_push = wr_lvl && !wr_lvl_q && periph && !done_s;
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         wr_lvl_q <= 1'b0;
      end else begin
         wr_lvl_q <= wr_lvl;
      end
   end

   // PROM fetch; waits for a free slot so the buffer never overflows
   cdp_fetch_e fs_q;
   logic [SW-1:0] settle_q;
   logic addr_oe_q;
   // No byte taken once the PROM pins are released
   assign fetch_push = (fs_q == FS_WAIT) && (settle_q == '0) && addr_oe_q;
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         fs_q <= FS_IDLE;
         settle_q <= '0;
      end else begin
         case (fs_q)
            FS_IDLE: begin
               if (mpar && !done_s && !fifo_full) begin
                  fs_q <= FS_WAIT;
                  settle_q <= SETTLE_LAST;
               end
            end
            FS_WAIT: begin
               if (settle_q == '0) begin
                  fs_q <= FS_IDLE;
               end else begin
                  settle_q <= settle_q - 1'b1;
               end
            end
            default: fs_q <= FS_IDLE;
         endcase
      end
   end

   // Start value reloaded until the address drive is on; mode and width settle together
   logic [ADDR_W-1:0] addr_q;
   logic [ADDR_W-1:0] addr_start;
   logic ext_oe_q;
   assign addr_start = (mode_s != MODE_MPDN) ? ADDR_UP_START : (ext_s ? ADDR_DN_EXT : ADDR_DN_BASE);
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         addr_q <= ADDR_UP_START;
      end else if (!addr_oe_q) begin
         addr_q <= addr_start;
      end else if (fetch_push) begin
         addr_q <= (mode_s == MODE_MPDN) ? addr_q - 1'b1 : addr_q + 1'b1;
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         addr_oe_q <= 1'b0;
         ext_oe_q <= 1'b0;
      end else begin
         addr_oe_q <= mpar && !done_s;
         ext_oe_q <= mpar && ext_s && !done_s;
      end
   end
   assign prom_addr_base_o = addr_q[ADDR_BASE_W-1:0];
   assign prom_addr_ext_o = addr_q[ADDR_W-1:ADDR_BASE_W];
   assign prom_addr_oe_o = addr_oe_q;
   assign prom_addr_ext_oe_o = ext_oe_q;

   // Serialiser with clock burst; a stalled drain freezes the clock
   logic [BYTE_W-1:0] sh_q;
   logic [3:0] sh_cnt_q;
   logic [DW-1:0] div_q;
   logic cfg_clock_q, cfg_clock_oe_q, bit_q, bit_vld_q, ready_q;
   logic slot_free, run, tick, emit;
   assign slot_free = !bit_vld_q || cfg_bit_ready_i;
   assign run = ((sh_cnt_q != '0) || cfg_clock_q) && slot_free;
   assign tick = run && (div_q == DIV_LAST);
   assign emit = tick && !cfg_clock_q;
   assign pop = (sh_cnt_q == '0) && !fifo_empty && !cfg_clock_q;

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         div_q <= '0;
         cfg_clock_q <= 1'b0;
      end else begin
         div_q <= (!run || tick) ? '0 : div_q + 1'b1;
         if (tick) begin
            cfg_clock_q <= !cfg_clock_q;
         end
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         sh_q <= '0;
         sh_cnt_q <= '0;
      end else if (pop) begin
         sh_q <= fifo_mem_q[rd_ptr_q];
         sh_cnt_q <= BITS_PER_BYTE;
      end else if (emit) begin
         sh_q <= {sh_q[BYTE_W-2:0], 1'b0};
         sh_cnt_q <= sh_cnt_q - 1'b1;
      end
   end

   // Set wins over the drain's acceptance
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         bit_q <= 1'b0;
         bit_vld_q <= 1'b0;
      end else if (emit) begin
         bit_q <= sh_q[BYTE_W-1];
         bit_vld_q <= 1'b1;
      end else if (cfg_bit_ready_i) begin
         bit_vld_q <= 1'b0;
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ready_q <= 1'b0;
         cfg_clock_oe_q <= 1'b0;
      end else begin
         ready_q <= fifo_empty && (sh_cnt_q == '0) && !bit_vld_q && !push_ok;
         cfg_clock_oe_q <= (mpar || (mode_s == MODE_APER)) && !done_s;
      end
   end
   assign cfg_clock_o = cfg_clock_q;
   assign cfg_clock_oe_o = cfg_clock_oe_q;
   assign cfg_bit_o = bit_q;
   assign cfg_bit_valid_o = bit_vld_q;

   // Status read drive
   logic pins_oe_q;
   logic [BYTE_W-1:0] pins_o_q;
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         pins_oe_q <= 1'b0;
         pins_o_q <= '0;
      end else begin
         pins_oe_q <= rd_lvl && periph && !done_s;
         pins_o_q <= {ready_q, RD_FILL};
      end
   end
   assign cfg_byte_pins_o = pins_o_q;
   assign cfg_byte_pins_oe_o = pins_oe_q;

   // Serial word crossing, system side
   logic tog_s1_q, tog_s2_q, tog_s3_q, ser_tog_q;
   assign ser_push = tog_s2_q ^ tog_s3_q;
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         tog_s1_q <= 1'b0;
         tog_s2_q <= 1'b0;
         tog_s3_q <= 1'b0;
      end else begin
         tog_s1_q <= ser_tog_q;
         tog_s2_q <= tog_s1_q;
         tog_s3_q <= tog_s2_q;
      end
   end

   // Link domain
   logic [6:0] c_s1_q, c_s2_q;
   logic cs_c, exp_c, done_c, loaded_c;
   logic [2:0] mode_c;
   assign {cs_c, exp_c, mode_c, done_c, loaded_c} = c_s2_q;
   always_ff @(posedge cfg_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         c_s1_q <= '0;
         c_s2_q <= '0;
      end else begin
         c_s1_q <= {chip_select_high_active_i, express_mode_i, mode_select_pins_i, cfg_done_i, cfg_loaded_i};
         c_s2_q <= c_s1_q;
      end
   end

   logic ser_act, din_a_q, din_b_q, dout_oe_q, dout_q;
   logic [6:0] sh_c_q;
   logic [2:0] bitn_q;
   assign ser_act = !done_c && (exp_c ? cs_c : ((mode_c == MODE_MSER) || (mode_c == MODE_SSER)));
   always_ff @(posedge cfg_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         din_a_q <= 1'b0;
         din_b_q <= 1'b0;
         dout_oe_q <= 1'b0;
      end else begin
         din_a_q <= cfg_byte_pins_i[0];
         din_b_q <= din_a_q;
         dout_oe_q <= !done_c;
      end
   end

   // Sender toggles once per byte; link clock must be slower than a few system cycles per byte
   always_ff @(posedge cfg_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         sh_c_q <= '0;
         bitn_q <= '0;
         ser_word_q <= '0;
         ser_tog_q <= 1'b0;
      end else if (ser_act) begin
         sh_c_q <= {sh_c_q[5:0], cfg_byte_pins_i[0]};
         bitn_q <= bitn_q + 1'b1;
         if (bitn_q == 3'h7) begin
            ser_word_q <= {sh_c_q, cfg_byte_pins_i[0]};
            ser_tog_q <= !ser_tog_q;
         end
      end
   end

   always_ff @(negedge cfg_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         dout_q <= 1'b0;
      end else begin
         dout_q <= exp_c ? loaded_c : din_b_q;
      end
   end
   assign ser_out_o = dout_q;
   assign ser_out_oe_o = dout_oe_q;

   // Checks, system domain
   sequence rd_seq;
      rd_lvl && periph && !done_s;
   endsequence
   sequence fetch_seq;
      fs_q == FS_IDLE ##1 fs_q == FS_WAIT;
   endsequence

   sel_gate_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      host_push |-> cs_s && !cs_n_s && $past(!wr_lvl))
      else $error("write taken while not selected");
   capture_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      host_push && !fifo_full && !pop |=> cnt_q == $past(cnt_q) + 1'b1)
      else $error("write strobe did not store a byte");
   status_rd_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      rd_seq |=> cfg_byte_pins_oe_o && cfg_byte_pins_o[6:0] == 7'h7f && cfg_byte_pins_o[7] == $past(ready_q))
      else $error("status read drive wrong");
   write_wins_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      sel && !ws_n_s && !rs_n_s |=> !cfg_byte_pins_oe_o)
      else $error("read drove pins during write");
   addr_step_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      fetch_push && mode_s == MODE_MPUP && $past(mode_s) == MODE_MPUP |=> addr_q == $past(addr_q) + 1'b1)
      else $error("address did not step up");
   ext_oe_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      mpar && !done_s |=> prom_addr_ext_oe_o == $past(ext_s) && prom_addr_oe_o)
      else $error("extended address enable wrong");
   fetch_len_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      fetch_seq |-> (fs_q == FS_WAIT && !fetch_push)[*8])
      else $error("fetch sampled before address settled");
   din_lsb_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      host_push && !fifo_full |=> fifo_mem_q[$past(wr_ptr_q)][0] == $past(byte_s[0]))
      else $error("byte bit zero not from serial pin");
   release_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      done_s |=> !cfg_byte_pins_oe_o && !prom_addr_oe_o && !cfg_clock_oe_o)
      else $error("pins not released after configuration");
   burst_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      emit |-> !cfg_clock_q ##1 cfg_clock_q && cfg_bit_valid_o)
      else $error("bit not tied to clock rise");
   busy_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      host_push |=> !ready_q ##1 !ready_q)
      else $error("ready shown while byte pending");

   // Checks, link domain
   exp_gate_a: assert property (@(posedge cfg_clk_i) disable iff (sys_rst_i)
      exp_c && !cs_c |=> $stable(bitn_q) && $stable(ser_tog_q))
      else $error("express chain ran while disabled");
   sample_a: assert property (@(posedge cfg_clk_i) disable iff (sys_rst_i)
      ser_act && bitn_q == 3'h7 |=> ser_word_q[0] == din_a_q)
      else $error("serial bit not sampled on rise");
   dout_delay_a: assert property (@(posedge cfg_clk_i) disable iff (sys_rst_i)
      !exp_c |-> ser_out_o == $past(din_a_q))
      else $error("forwarded bit misplaced");
   exp_status_a: assert property (@(posedge cfg_clk_i) disable iff (sys_rst_i)
      exp_c |-> ser_out_o == loaded_c)
      else $error("express status not forwarded");
endmodule : cdp_config_data_port

// file: test/cdp_prom_model.sv
// Configuration PROM model for master parallel fetches.
// Assumes the bench resolves the shared data pins from its drive flag.
`timescale 1ns/1ps
module cdp_prom_model (
   input wire logic [cdp_pkg::ADDR_W-1:0] addr_i,
   input wire logic ce_i,
   output logic [cdp_pkg::BYTE_W-1:0] data_o,
   output logic drive_o
);
   import cdp_pkg::*;
   // Byte follows the address, so a wrong step or start shows
   assign data_o = addr_i[7:0] + 8'h3c;
   // Output enable tied to the address enable: no drive once released
   assign drive_o = ce_i;
endmodule : cdp_prom_model

// file: test/cdp_config_data_port_bench.sv
// Self-checking bench for the configuration data port.
// Assumes pull-ups on the data and upper address pins when nobody drives them.
`timescale 1ns/1ps
module cdp_config_data_port_bench;
   import cdp_pkg::*;
   logic clk_i = 0, sys_rst_i = 1, cfg_clk_i = 0, link_en = 0;
   logic cs_n = 1, cs1 = 0, ws_n = 1, rs_n = 1, expr = 0, ext_en = 0, done = 0, loaded = 0;
   logic [2:0] mode = 3'h5;
   logic [7:0] host_data = 8'hff, sh = 8'h00;
   logic host_drive = 0, ready = 0, clk_prev = 0;
   logic [1:0] drain = 2'h0;
   logic [7:0] pins_o, pins, prom_data;
   logic pins_oe, addr_oe, ext_oe, clk_o, clk_oe, ser_out, ser_oe, bit_o, bit_vld, prom_drv;
   logic [17:0] base;
   logic [3:0] ext;
   int bad_count = 0, comparisons = 0, nbits = 0, tick = 0, rises = 0;
   logic [7:0] q[$];
   always #4 clk_i = ~clk_i;
   // Link clock stands still between frames
   always begin
      #15;
      if (link_en) cfg_clk_i = ~cfg_clk_i;
   end
   assign pins = pins_oe ? pins_o : prom_drv ? prom_data : host_drive ? host_data : 8'hff;
   cdp_config_data_port #(.CFG_CLOCK_HALF(2)) i_cdp_config_data_port (
      .clk_i(clk_i), .sys_rst_i(sys_rst_i), .cfg_clk_i(cfg_clk_i),
      .chip_select_low_active_n_i(cs_n), .chip_select_high_active_i(cs1),
      .write_strobe_n_i(ws_n), .read_strobe_n_i(rs_n), .mode_select_pins_i(mode),
      .express_mode_i(expr), .addr_ext_en_i(ext_en), .cfg_done_i(done), .cfg_loaded_i(loaded),
      .cfg_byte_pins_i(pins), .cfg_byte_pins_o(pins_o), .cfg_byte_pins_oe_o(pins_oe),
      .prom_addr_base_o(base), .prom_addr_ext_o(ext), .prom_addr_oe_o(addr_oe),
      .prom_addr_ext_oe_o(ext_oe), .cfg_clock_o(clk_o), .cfg_clock_oe_o(clk_oe),
      .ser_out_o(ser_out), .ser_out_oe_o(ser_oe), .cfg_bit_o(bit_o),
      .cfg_bit_valid_o(bit_vld), .cfg_bit_ready_i(ready));
   cdp_prom_model i_cdp_prom_model (
      .addr_i({ext_oe ? ext : 4'hf, addr_oe ? base : 18'h3ffff}),
      .ce_i(addr_oe), .data_o(prom_data), .drive_o(prom_drv));
   // Drain side: fast, stalled or every other cycle
   always @(posedge clk_i) begin
      if (bit_vld && ready) begin
         sh = {sh[6:0], bit_o};
         nbits++;
         if (nbits == 8) begin
            q.push_back(sh);
            nbits = 0;
         end
      end
      tick++;
      if (clk_o && !clk_prev) rises++;
      clk_prev = clk_o;
      ready <= (drain == 2'h0) || (drain == 2'h2 && tick[0]);
   end
   task automatic test_done;
      $display("comparisons %0d bad_count %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : test_done
   task automatic chk_flag(input string what, input logic e, input logic g);
      comparisons++;
      if (g !== e) begin
         bad_count++;
         $display("unexpected %s expected %h seen %h", what, e, g);
      end
   endtask : chk_flag
   task automatic chk_val(input string what, input logic [21:0] e, input logic [21:0] g);
      comparisons++;
      if (g !== e) begin
         bad_count++;
         $display("unexpected %s expected %h seen %h", what, e, g);
      end
   endtask : chk_val
   task automatic start(input logic [2:0] m, input logic x, input logic e);
      @(posedge clk_i);
      sys_rst_i <= 1;
      mode <= m;
      expr <= x;
      ext_en <= e;
      done <= 0;
      drain <= 2'h0;
      link_en = 1;
      // Link clock parked low before release, so no stray bit is shifted
      @(negedge cfg_clk_i);
      link_en = 0;
      repeat (5) @(posedge clk_i);
      chk_flag("valid in reset", 0, bit_vld);
      sys_rst_i <= 0;
      nbits = 0;
      rises = 0;
      q.delete();
      repeat (4) @(posedge clk_i);
   endtask : start
   task automatic clocks(input int n);
      link_en = 1;
      repeat (n) @(negedge cfg_clk_i);
      link_en = 0;
   endtask : clocks
   task automatic host_write(input logic [7:0] b, input logic sn, input logic s1, input logic both);
      @(posedge clk_i);
      cs_n <= sn;
      cs1 <= s1;
      host_data <= b;
      host_drive <= 1;
      ws_n <= 0;
      rs_n <= !both;
      repeat (6) @(posedge clk_i);
      if (both) chk_flag("pin drive on overlap", 0, pins_oe);
      ws_n <= 1;
      rs_n <= 1;
      repeat (2) @(posedge clk_i);
      host_drive <= 0;
      repeat (4) @(posedge clk_i);
   endtask : host_write
   task automatic host_read(input logic rdy);
      @(posedge clk_i);
      cs_n <= 0;
      cs1 <= 1;
      rs_n <= 0;
      repeat (6) @(posedge clk_i);
      chk_flag("status drive", 1, pins_oe);
      chk_val("status byte", {14'h0, rdy, 7'h7f}, {14'h0, pins});
      rs_n <= 1;
      repeat (6) @(posedge clk_i);
   endtask : host_read
   task automatic get_byte(input logic [7:0] e);
      int n;
      for (n = 0; n < 3000 && q.size() == 0; n++) @(posedge clk_i);
      if (q.size() == 0) chk_val("byte arrival", 22'h1, 22'h0);
      else chk_val("serial byte", {14'h0, e}, {14'h0, q.pop_front()});
   endtask : get_byte
   task automatic no_byte;
      repeat (300) @(posedge clk_i);
      chk_val("byte count", 22'h0, 22'(q.size()));
   endtask : no_byte
   task automatic t_periph;
      start(3'h5, 0, 0);
      host_read(1);
      drain <= 2'h1;
      host_write(8'ha5, 0, 1, 0);
      host_read(0);
      host_write(8'h3c, 0, 1, 0);
      chk_flag("clock drive", 1, clk_oe);
      drain <= 2'h2;
      get_byte(8'ha5);
      get_byte(8'h3c);
      repeat (20) @(posedge clk_i);
      chk_val("clock rises", 22'h10, 22'(rises));
      chk_flag("clock idle", 0, clk_o);
      host_read(1);
   endtask : t_periph
   task automatic t_select;
      start(3'h3, 0, 0);
      host_write(8'h11, 1, 1, 0);
      host_write(8'h22, 0, 0, 0);
      no_byte();
      host_write(8'hc3, 0, 1, 1);
      get_byte(8'hc3);
      chk_flag("clock drive", 0, clk_oe);
      done <= 1;
      rs_n <= 0;
      repeat (8) @(posedge clk_i);
      chk_flag("status drive", 0, pins_oe);
      rs_n <= 1;
   endtask : t_select
   task automatic t_mpar(input logic [2:0] m, input logic e, input logic [21:0] a0, input logic [7:0] b0);
      int n;
      start(m, 0, e);
      for (n = 0; n < 50 && addr_oe !== 1; n++) @(posedge clk_i);
      chk_flag("address drive", 1, addr_oe);
      chk_flag("upper address drive", e, ext_oe);
      chk_val("start address", a0[17:0], base);
      if (e) chk_val("upper start address", a0[21:18], ext);
      get_byte(b0);
      get_byte(m == MODE_MPUP ? b0 + 8'h1 : b0 - 8'h1);
   endtask : t_mpar
   task automatic t_serial(input logic [2:0] m);
      logic [9:0] pat;
      int j;
      pat = 10'h2d0;
      start(m, 0, 0);
      host_drive <= 1;
      host_data <= {7'h7f, pat[9]};
      link_en = 1;
      for (j = 1; j <= 10; j++) begin
         @(negedge cfg_clk_i);
         #1;
         if (j >= 2) chk_flag("forwarded bit", pat[11 - j], ser_out);
         if (j < 10) host_data[0] <= pat[9 - j];
      end
      link_en = 0;
      chk_flag("serial out drive", 1, ser_oe);
      get_byte(8'hb4);
      host_drive <= 0;
   endtask : t_serial
   task automatic t_express;
      start(3'h7, 1, 0);
      cs1 <= 0;
      loaded <= 1;
      clocks(12);
      no_byte();
      chk_flag("express status", 1, ser_out);
      loaded <= 0;
      clocks(6);
      chk_flag("express status", 0, ser_out);
   endtask : t_express
   task automatic t_done;
      start(3'h4, 0, 1);
      repeat (20) @(posedge clk_i);
      done <= 1;
      clocks(4);
      repeat (10) @(posedge clk_i);
      chk_flag("address drive", 0, addr_oe);
      chk_flag("upper address drive", 0, ext_oe);
      chk_flag("clock drive", 0, clk_oe);
      chk_flag("serial out drive", 0, ser_oe);
      cs_n <= 0;
      cs1 <= 1;
      rs_n <= 0;
      repeat (8) @(posedge clk_i);
      chk_flag("status drive", 0, pins_oe);
      rs_n <= 1;
   endtask : t_done
   initial begin
      t_periph();
      t_select();
      t_mpar(3'h4, 0, 22'h000000, 8'h3c);
      t_mpar(3'h6, 1, 22'h3fffff, 8'h3b);
      t_serial(3'h7);
      t_serial(3'h0);
      t_express();
      t_done();
      test_done();
   end
   // Whole run needs well under this span
   initial begin
      #400000;
      bad_count++;
      test_done();
   end
endmodule : cdp_config_data_port_bench
